// ==== bicnv_pkg.sv ====
// Purpose: shared constants and types of the boot interface config byte
// Assumes: any-register commands carry a 3 or 4 byte address
// Notes:   otp_merge folds a write into the one-time-programmable byte
`default_nettype none
package bicnv_pkg;
	// ----------------------------------------------------------------
	// commands and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_ANY_RD    = 8'h65;
	localparam logic [7:0] CMD_ANY_WR    = 8'h71;
	localparam int         AL_BIT        = 7;
	localparam int         WIDE_BIT      = 6;
	localparam int         L3R_BIT       = 5;
	localparam int         RSV_BIT       = 4;
	localparam int         LAT_MSB       = 3;
	localparam int         STAT_BUSY_BIT = 0;
	localparam logic [7:0] NV_RESET      = 8'h08;
	localparam logic [7:0] RSV_MASK      = 8'h10;
	localparam logic [7:0] STAT_BUSY     = 8'h01;
	// ----------------------------------------------------------------
	// link timing, in sck edges
	// ----------------------------------------------------------------
	localparam int         CMD_BITS      = 8;
	localparam int         SER_W         = 1;
	localparam int         WIDE_W        = 4;
	localparam logic [5:0] CMD_E_SER     = 6'(CMD_BITS / SER_W);
	localparam logic [5:0] CMD_E_WIDE    = 6'(CMD_BITS / WIDE_W);
	localparam logic [5:0] ADR3_E_SER    = 6'(3 * CMD_BITS / SER_W);
	localparam logic [5:0] ADR3_E_WIDE   = 6'(3 * CMD_BITS / WIDE_W);
	localparam logic [5:0] ADR4_E_SER    = 6'(4 * CMD_BITS / SER_W);
	localparam logic [5:0] ADR4_E_WIDE   = 6'(4 * CMD_BITS / WIDE_W);
	// ----------------------------------------------------------------
	// types and helpers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LK_CMD   = 3'b000,
		LK_ADDR  = 3'b001,
		LK_DUMMY = 3'b010,
		LK_DATA  = 3'b011,
		LK_SKIP  = 3'b100
	} bicnv_phase_t;
	// a bit may leave its default once and never return
	function automatic logic [7:0] otp_merge(input logic [7:0] cur, input logic [7:0] req);
		otp_merge = (((cur ^ NV_RESET) | (req ^ NV_RESET)) ^ NV_RESET) & ~RSV_MASK;
	endfunction
endpackage
`default_nettype wire

// ==== bicnv_if.sv ====
// Purpose: carrier between core and serial link logic
// Assumes: core-to-link words change only between frames
// Notes:   write request crosses by toggle, its words held stable
`timescale 1ns/1ps
`default_nettype none
interface bicnv_if;
	logic        wide_cmd;
	logic        addr4;
	logic [3:0]  dummy;
	logic [7:0]  rd_nv;
	logic [7:0]  rd_live;
	logic [7:0]  rd_stat;
	logic        wr_tgl;
	logic [31:0] wr_addr;
	logic [7:0]  wr_data;
	modport core (output wide_cmd, addr4, dummy, rd_nv, rd_live, rd_stat,
		input wr_tgl, wr_addr, wr_data);
	modport link (input wide_cmd, addr4, dummy, rd_nv, rd_live, rd_stat,
		output wr_tgl, wr_addr, wr_data);
endinterface
`default_nettype wire

// ==== bicnv_sync.sv ====
// Purpose: two-stage level synchroniser
// Assumes: input is a level from another domain
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module bicnv_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bicnv_sync_t;
	bicnv_sync_t st;
	bicnv_sync_t next_st;
	always_comb begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
	assign q = st.s2;
endmodule // bicnv_sync
`default_nettype wire

// ==== bicnv_link.sv ====
// Purpose: serial link end of the any-register read and write commands
// Assumes: clock mode 0, sample on rising sck, drive on falling sck
// Notes:   frame state is cleared by chip select high
`timescale 1ns/1ps
`default_nettype none
module bicnv_link
	import bicnv_pkg::*;
#(
	parameter logic [31:0] NV_ADDR   = 32'h0000_0003,
	parameter logic [31:0] LIVE_ADDR = 32'h0080_0003,
	parameter logic [31:0] STAT_ADDR = 32'h0080_0000
) (
	// link pins
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       rst_b,
	input  wire logic [3:0] io_in,
	output logic      [3:0] io_out,
	output logic      [3:0] io_oe,
	// core side
	bicnv_if.link           lnk
);
	typedef struct packed {
		bicnv_phase_t phase;
		logic         wide;
		logic         addr4;
		logic [3:0]   dummy;
		logic [5:0]   cnt;
		logic [31:0]  sh;
		logic [7:0]   op;
		logic [31:0]  addr;
		logic [7:0]   tx;
	} bicnv_frame_t;
	typedef struct packed {
		logic        wr_tgl;
		logic [31:0] wr_addr;
		logic [7:0]  wr_data;
	} bicnv_hold_t;
	typedef struct packed {
		logic [3:0] oe;
		logic [3:0] d;
	} bicnv_drive_t;
	bicnv_frame_t fr;
	bicnv_frame_t next_fr;
	bicnv_hold_t  hold;
	bicnv_hold_t  next_hold;
	bicnv_drive_t dr;
	bicnv_drive_t next_dr;
	logic         frame_rst_b;
	logic         first;
	logic         w4;
	logic         a4;
	logic [31:0]  sh_in;
	logic [31:0]  new_addr;
	logic [31:0]  tgt;
	logic [7:0]   rd_byte;
	logic [5:0]   cmd_n;
	logic [5:0]   addr_n;
	logic [5:0]   byte_n;
	assign frame_rst_b = rst_b & ~cs_n;
	// ----------------------------------------------------------------
	// receive and decode, rising sck
	// ----------------------------------------------------------------
	always_comb begin
		next_fr   = fr;
		next_hold = hold;
		first     = (fr.phase == LK_CMD) && (fr.cnt == 6'h00);
		// width is fixed per frame so a mid-frame switch cannot tear it
		w4        = first ? lnk.wide_cmd : fr.wide;
		a4        = first ? lnk.addr4 : fr.addr4;
		if (first) begin
			next_fr.wide  = lnk.wide_cmd;
			next_fr.addr4 = lnk.addr4;
			next_fr.dummy = lnk.dummy;
		end
		sh_in    = w4 ? {fr.sh[27:0], io_in} : {fr.sh[30:0], io_in[0]};
		cmd_n    = w4 ? CMD_E_WIDE : CMD_E_SER;
		addr_n   = a4 ? (w4 ? ADR4_E_WIDE : ADR4_E_SER) : (w4 ? ADR3_E_WIDE : ADR3_E_SER);
		byte_n   = w4 ? CMD_E_WIDE : CMD_E_SER;
		new_addr = a4 ? sh_in : {8'h00, sh_in[23:0]};
		tgt      = (fr.phase == LK_ADDR) ? new_addr : fr.addr;
		if (tgt == NV_ADDR) begin
			rd_byte = lnk.rd_nv;
		end else if (tgt == LIVE_ADDR) begin
			rd_byte = lnk.rd_live;
		end else if (tgt == STAT_ADDR) begin
			rd_byte = lnk.rd_stat;
		end else begin
			rd_byte = 8'h00;
		end
		next_fr.sh  = sh_in;
		next_fr.cnt = fr.cnt + 6'h01;
		case (fr.phase)
			LK_CMD: begin
				if (next_fr.cnt == cmd_n) begin
					next_fr.op  = sh_in[7:0];
					next_fr.cnt = 6'h00;
					if (sh_in[7:0] == CMD_ANY_RD || sh_in[7:0] == CMD_ANY_WR) begin
						next_fr.phase = LK_ADDR;
					end else begin
						next_fr.phase = LK_SKIP;
					end
				end
			end
			LK_ADDR: begin
				if (next_fr.cnt == addr_n) begin
					next_fr.addr = new_addr;
					next_fr.cnt  = 6'h00;
					if (fr.op == CMD_ANY_WR || fr.dummy == 4'h0) begin
						next_fr.phase = LK_DATA;
						next_fr.tx    = rd_byte;
					end else begin
						next_fr.phase = LK_DUMMY;
					end
				end
			end
			LK_DUMMY: begin
				if (next_fr.cnt == {2'b00, fr.dummy}) begin
					next_fr.cnt   = 6'h00;
					next_fr.phase = LK_DATA;
					next_fr.tx    = rd_byte;
				end
			end
			LK_DATA: begin
				next_fr.tx = w4 ? {fr.tx[3:0], 4'h0} : {fr.tx[6:0], 1'b0};
				if (next_fr.cnt == byte_n) begin
					next_fr.cnt = 6'h00;
					next_fr.tx  = rd_byte;
					if (fr.op == CMD_ANY_WR) begin
						next_hold.wr_tgl  = ~hold.wr_tgl;
						next_hold.wr_addr = fr.addr;
						next_hold.wr_data = sh_in[7:0];
						next_fr.phase     = LK_SKIP;
					end
				end
			end
			LK_SKIP: begin
				next_fr.cnt = fr.cnt;
			end
			default: begin
				next_fr.phase = LK_SKIP;
			end
		endcase
	end
	always_ff @(posedge sck or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			fr <= '0;
		end else begin
			fr <= next_fr;
		end
	end
	// request words survive the frame, so only system reset clears them
	always_ff @(posedge sck or negedge rst_b) begin
		if (!rst_b) begin
			hold <= '0;
		end else begin
			hold <= next_hold;
		end
	end
	// ----------------------------------------------------------------
	// read data drive, falling sck
	// ----------------------------------------------------------------
	always_comb begin
		next_dr    = dr;
		next_dr.oe = 4'h0;
		next_dr.d  = 4'h0;
		if (fr.phase == LK_DATA && fr.op == CMD_ANY_RD) begin
			next_dr.oe = fr.wide ? 4'hf : 4'h2;
			next_dr.d  = fr.wide ? fr.tx[7:4] : {2'b00, fr.tx[7], 1'b0};
		end
	end
	always_ff @(negedge sck or negedge frame_rst_b) begin
		if (!frame_rst_b) begin
			dr <= '0;
		end else begin
			dr <= next_dr;
		end
	end
	assign io_out      = dr.d;
	assign io_oe       = dr.oe;
	assign lnk.wr_tgl  = hold.wr_tgl;
	assign lnk.wr_addr = hold.wr_addr;
	assign lnk.wr_data = hold.wr_data;
endmodule // bicnv_link
`default_nettype wire

// ==== bicnv_top.sv ====
// Purpose: non-volatile interface boot config byte with its live copy
// Assumes: sck is the link clock, stopped outside frames
// Notes:   rst_b stands for power-on with a blank byte
//
// Functional notes
// - byte read by 65h, written by 71h
// - bit 7 sets default address length
// - four address bytes when long length selected
// - bit 6 sets default command width
// - programming wide command also programs quad default
// - host polls busy after programming wide bit
// - clearing live wide bit returns serial instructions
// - programmed wide command bit never returns zero
// - bit 5 enables data line three reset
// - line three selection loaded on every reset
// - bit 4 reserved, reads zero
// - bits 3..0 give read dummy count
// - latency default 1000, bit 3 clears once
// - dummy count applies to variable latency reads
// - each bit leaves default only once
`timescale 1ns/1ps
`default_nettype none
module bicnv_top
	import bicnv_pkg::*;
#(
	parameter logic [31:0] NV_ADDR     = 32'h0000_0003,
	parameter logic [31:0] LIVE_ADDR   = 32'h0080_0003,
	parameter logic [31:0] STAT_ADDR   = 32'h0080_0000,
	parameter int          PROG_CYCLES = 16
) (
	// system
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       ce,
	// serial link pins
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_in,
	output logic      [3:0] io_out,
	output logic      [3:0] io_oe,
	// neighbouring logic
	input  wire logic       reload_req,
	input  wire logic       quad_on,
	// live interface controls, quad width default and busy
	output logic            addr_len,
	output logic            wide_cmd,
	output logic            line3_reset_en,
	output logic      [3:0] dummy_count,
	output logic            quad_width_default,
	output logic            busy
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  nv;
		logic [7:0]  live;
		logic [7:0]  pend;
		logic [15:0] cnt;
		logic        busy;
		logic        quad_def;
		logic        tgl_d;
	} bicnv_core_t;
	bicnv_core_t s;
	bicnv_core_t next_s;
	bicnv_if     lnk ();
	logic        tgl_s;
	logic [1:0]  pins_s;
	logic        cs_s;
	logic        io3_s;
	logic        wr_evt;
	logic        nv_hit;
	logic        live_hit;
	logic        l3_rst;
	logic [7:0]  merged;
	// ----------------------------------------------------------------
	// link and crossings
	// ----------------------------------------------------------------
	bicnv_link #(
		.NV_ADDR   (NV_ADDR),
		.LIVE_ADDR (LIVE_ADDR),
		.STAT_ADDR (STAT_ADDR)
	) u_link (
		.sck    (sck),
		.cs_n   (cs_n),
		.rst_b  (rst_b),
		.io_in  (io_in),
		.io_out (io_out),
		.io_oe  (io_oe),
		.lnk    (lnk.link)
	);
	bicnv_sync #(
		.W (1)
	) u_tgl_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.d     (lnk.wr_tgl),
		.q     (tgl_s)
	);
	bicnv_sync #(
		.W (2)
	) u_pin_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.d     ({cs_n, io_in[3]}),
		.q     (pins_s)
	);
	assign cs_s  = pins_s[1];
	assign io3_s = pins_s[0];
	// ----------------------------------------------------------------
	// core
	// ----------------------------------------------------------------
	assign wr_evt   = s.tgl_d != tgl_s;
	assign nv_hit   = lnk.wr_addr == NV_ADDR;
	assign live_hit = lnk.wr_addr == LIVE_ADDR;
	// line three acts as reset only while not carrying data
	assign l3_rst   = s.live[L3R_BIT] && (cs_s || !quad_on) && !io3_s;
	assign merged   = otp_merge(s.nv, s.pend);
	always_comb begin
		next_s       = s;
		next_s.tgl_d = tgl_s;
		if (wr_evt) begin
			if (nv_hit && !s.busy) begin
				next_s.busy = 1'b1;
				next_s.cnt  = 16'h0000;
				next_s.pend = lnk.wr_data;
			end else if (live_hit) begin
				// live copy is not one-time, any bit but reserved bit 4 may flip
				next_s.live = lnk.wr_data & ~RSV_MASK;
			end
		end
		if (s.busy) begin
			next_s.cnt = s.cnt + 16'h0001;
			if (s.cnt == 16'(PROG_CYCLES - 1)) begin
				next_s.busy = 1'b0;
				next_s.nv   = merged;
				if (merged[WIDE_BIT]) begin
					next_s.quad_def = 1'b1;
				end
			end
		end
		// reset of the live copy wins over a same-cycle live write
		if (reload_req || l3_rst) begin
			next_s.live = s.nv;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s      <= '0;
			s.nv   <= NV_RESET;
			s.live <= NV_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign addr_len           = s.live[AL_BIT];
	assign wide_cmd           = s.live[WIDE_BIT];
	assign line3_reset_en     = s.live[L3R_BIT];
	assign dummy_count        = s.live[LAT_MSB:0];
	assign quad_width_default = s.quad_def;
	assign busy               = s.busy;
	assign lnk.wide_cmd       = s.live[WIDE_BIT];
	assign lnk.addr4          = s.live[AL_BIT];
	assign lnk.dummy          = s.live[LAT_MSB:0];
	assign lnk.rd_nv          = s.nv;
	assign lnk.rd_live        = s.live;
	// busy is read as a level; host polls it repeatedly
	assign lnk.rd_stat        = s.busy ? STAT_BUSY : 8'h00;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_RSV_ZERO: assert property (
		s.nv[RSV_BIT] == 1'b0 && s.live[RSV_BIT] == 1'b0)
		else $error("reserved bit set");
	AST_OTP_KEEP: assert property (
		((($past(s.nv) ^ NV_RESET) & ~(s.nv ^ NV_RESET)) == 8'h00))
		else $error("programmed bit returned to default");
	AST_LAT_ONCE: assert property (
		!s.nv[LAT_MSB] |=> !s.nv[LAT_MSB])
		else $error("latency bit 3 returned to one");
	AST_WIDE_OTP: assert property (
		s.nv[WIDE_BIT] |=> s.nv[WIDE_BIT])
		else $error("wide command bit cleared");
	AST_QUAD_TIED: assert property (
		s.nv[WIDE_BIT] |-> s.quad_def)
		else $error("quad default not programmed with wide bit");
	AST_NV_CMD: assert property (
		ce && wr_evt && nv_hit && !s.busy |=> busy && s.pend == $past(lnk.wr_data))
		else $error("nv write not started");
	AST_BUSY_HOLD: assert property (
		$rose(s.busy) |-> s.busy [*4])
		else $error("busy too short");
	AST_COMMIT: assert property (
		$fell(s.busy) |-> s.nv == otp_merge($past(s.nv), $past(s.pend)))
		else $error("nv commit wrong");
	AST_RELOAD: assert property (
		ce && (reload_req || l3_rst) |=> s.live == $past(s.nv))
		else $error("live copy not reloaded");
	AST_AL_DEF: assert property (
		ce && reload_req |=> addr_len == $past(s.nv[AL_BIT]))
		else $error("address length default wrong");
	AST_WIDE_DEF: assert property (
		ce && reload_req |=> wide_cmd == $past(s.nv[WIDE_BIT]))
		else $error("command width default wrong");
	AST_L3_OFF: assert property (
		ce && !s.live[L3R_BIT] && !reload_req && !wr_evt |=> s.live == $past(s.live))
		else $error("line three reset acted while disabled");
	AST_SERIAL_BACK: assert property (
		ce && wr_evt && live_hit && !reload_req && !l3_rst
			&& !lnk.wr_data[WIDE_BIT] |=> !wide_cmd)
		else $error("wide mode not left");
	COV_NV_PROG: cover property ($fell(s.busy) && s.nv[WIDE_BIT]);
	COV_WIDE_ON: cover property ($rose(wide_cmd));
	COV_L3_RST: cover property (ce && l3_rst);
	COV_LIVE_WR: cover property (ce && wr_evt && live_hit);
endmodule // bicnv_top
`default_nettype wire

// ==== bicnv_host.sv ====
// Purpose: host serial flash controller model that runs link frames
// Assumes: clock mode 0, sck stands low outside frames
// Notes:   released lines show inverted last value, line 3 held high
`timescale 1ns/1ps
`default_nettype none
module bicnv_host
	import bicnv_pkg::*;
(
	// link pins driven by the host
	output logic       sck,
	output logic       cs_n,
	output logic [3:0] io_h,
	// resolved data lines and device enables
	input  wire logic [3:0] io,
	input  wire logic [3:0] oe
);
	localparam realtime HALF = 62.5;
	logic [3:0] oe_seen;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io_h = 4'hf;
		oe_seen = 4'h0;
	end
	// ----------------------------------------------------------------
	// edges
	// ----------------------------------------------------------------
	// line 3 stays high, a low there resets the device
	task automatic line3(input logic lv);
		io_h[3] = lv;
	endtask
	task automatic edge_out(input logic [3:0] d);
		io_h = d;
		#(HALF) sck = 1'b1;
		#(HALF) sck = 1'b0;
	endtask
	task automatic shift_out(input logic [31:0] d, input int n, input logic w);
		for (int i = n - 1; i >= 0; i -= (w ? 4 : 1)) begin
			if (w)
				edge_out(4'(d >> (i - 3)));
			else
				edge_out({1'b1, ~io_h[2:1], d[i]});
		end
	endtask
	// data sampled on rising sck, device moved it on the falling one
	task automatic shift_in(input logic w, output logic [7:0] d);
		d = 8'h00;
		for (int i = 0; i < 8; i += (w ? 4 : 1)) begin
			io_h = {1'b1, ~io_h[2:0]};
			#(HALF) sck = 1'b1;
			d = w ? {d[3:0], io} : {d[6:0], io[1]};
			oe_seen = oe;
			#(HALF) sck = 1'b0;
		end
	endtask
	// ----------------------------------------------------------------
	// one command per frame
	// ----------------------------------------------------------------
	task automatic frame(input logic w, input logic a4, input logic [7:0] op,
		input logic [31:0] adr, input logic [7:0] wd, input int nd,
		output logic [7:0] rd);
		#(HALF) cs_n = 1'b0;
		oe_seen = 4'h0;
		shift_out({24'h0, op}, 8, w);
		shift_out(adr, a4 ? 32 : 24, w);
		rd = 8'h00;
		if (op == CMD_ANY_WR) begin
			shift_out({24'h0, wd}, 8, w);
		end else begin
			repeat (nd) edge_out({1'b1, ~io_h[2:0]});
			shift_in(w, rd);
		end
		#(HALF) cs_n = 1'b1;
		io_h = {1'b1, ~io_h[2:0]};
	endtask
endmodule // bicnv_host
`default_nettype wire

// ==== bicnv_top_tb.sv ====
// Purpose: self-checking bench of the boot interface config byte
// Assumes: host model runs frames, sck only runs within them
// Notes:   long programming time so busy shows in a status poll
`timescale 1ns/1ps
`default_nettype none
module bicnv_top_tb
	import bicnv_pkg::*;
;
	localparam logic [31:0] NV_A = 32'h0000_0003;
	localparam logic [31:0] LV_A = 32'h0080_0003;
	localparam logic [31:0] ST_A = 32'h0080_0000;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       reload_req = 1'b0;
	logic       sck;
	logic       cs_n;
	logic       addr_len;
	logic       wide_cmd;
	logic       l3;
	logic       busy;
	logic       qwd;
	logic [3:0] io_h;
	logic [3:0] io_w;
	logic [3:0] io_out;
	logic [3:0] io_oe;
	logic [3:0] dummy_count;
	logic [7:0] live_o;
	logic [7:0] v;
	int         n_errors = 0;
	int         total_checks = 0;
	always #12.5 clk = ~clk;
	assign io_w = (io_oe & io_out) | (~io_oe & io_h);
	assign live_o = {addr_len, wide_cmd, l3, 1'b0, dummy_count};
	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	// ce and quad_on tied: quad on keeps line 3 reset to cs high only
	bicnv_top #(.NV_ADDR(NV_A), .LIVE_ADDR(LV_A), .STAT_ADDR(ST_A),
		.PROG_CYCLES(300)) dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1),
		.sck(sck), .cs_n(cs_n), .io_in(io_w), .io_out(io_out),
		.io_oe(io_oe), .reload_req(reload_req), .quad_on(1'b1),
		.addr_len(addr_len), .wide_cmd(wide_cmd), .line3_reset_en(l3),
		.dummy_count(dummy_count), .quad_width_default(qwd), .busy(busy));
	bicnv_host host_u (.sck(sck), .cs_n(cs_n), .io_h(io_h), .io(io_w),
		.oe(io_oe));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clk);
		#3;
	endtask
	task automatic rd(input logic w, input logic a4, input logic [31:0] a, input int nd);
		host_u.frame(w, a4, CMD_ANY_RD, a, 8'h00, nd, v);
	endtask
	// settle time before any following frame
	task automatic wr(input logic w, input logic a4, input logic [31:0] a, input logic [7:0] d);
		host_u.frame(w, a4, CMD_ANY_WR, a, d, 0, v);
		clks(6);
	endtask
	task automatic reload();
		reload_req = 1'b1;
		clks(1);
		reload_req = 1'b0;
		clks(2);
	endtask
	task automatic pulse3();
		host_u.line3(1'b0);
		clks(8);
		host_u.line3(1'b1);
		clks(3);
	endtask
	task automatic prog_nv(input logic [7:0] d, input int nd);
		int n;
		n = 0;
		wr(0, 0, NV_A, d);
		check({7'h0, busy}, 8'h01);
		rd(0, 0, ST_A, nd);
		check({7'h0, v[STAT_BUSY_BIT]}, 8'h01);
		while (v[STAT_BUSY_BIT] !== 1'b0 && n < 8) begin
			rd(0, 0, ST_A, nd);
			n++;
		end
		check({7'h0, busy}, 8'h00);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic s_reset();
		check(live_o, 8'h08);
		check({6'h0, busy, qwd}, 8'h00);
		rd(0, 0, NV_A, 8);
		check(v, 8'h08);
	endtask
	task automatic s_live();
		wr(0, 0, LV_A, 8'h9f);
		check(live_o, 8'h8f);
		rd(0, 1, LV_A, 15);
		check(v, 8'h8f);
		reload();
		check(live_o, 8'h08);
	endtask
	task automatic s_prog();
		prog_nv(8'h01, 8);
		rd(0, 0, NV_A, 8);
		check(v, 8'h01);
		check(live_o, 8'h08);
		prog_nv(8'h48, 8);
		check({7'h0, qwd}, 8'h01);
		prog_nv(8'h00, 8);
		rd(0, 0, NV_A, 8);
		check(v, 8'h41);
		reload();
		check(live_o, 8'h41);
	endtask
	task automatic s_wide();
		rd(1, 0, NV_A, 1);
		check(v, 8'h41);
		check({4'h0, host_u.oe_seen}, 8'h0f);
		wr(1, 0, LV_A, 8'h00);
		check(live_o, 8'h00);
		rd(0, 0, NV_A, 0);
		check(v, 8'h41);
		check({4'h0, host_u.oe_seen}, 8'h02);
	endtask
	// unknown opcode and unmapped address
	task automatic s_refuse();
		host_u.frame(0, 0, 8'h03, NV_A, 8'h00, 0, v);
		check({4'h0, host_u.oe_seen}, 8'h00);
		rd(0, 0, 32'h0000_0010, 0);
		check(v, 8'h00);
	endtask
	task automatic s_line3();
		pulse3();
		check(live_o, 8'h00);
		wr(0, 0, LV_A, 8'h20);
		check(live_o, 8'h20);
		pulse3();
		check(live_o, 8'h41);
	endtask
	// ----------------------------------------------------------------
	// run
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clks(8);
		rst_b = 1'b1;
		clks(2);
		s_reset();
		s_live();
		s_prog();
		s_wide();
		s_refuse();
		s_line3();
		wrap_up();
	end
	// a hung handshake ends here
	initial begin
		#1_000_000;
		n_errors++;
		wrap_up();
	end
endmodule // bicnv_top_tb
`default_nettype wire
